// ### rtl/hsc_regs.svh
// register map, field positions, scale factors and timing counts
`ifndef HSC_REGS_SVH
`define HSC_REGS_SVH
`define CLK_MHZ 100
`define T_CARRIER_US 50
`define T_TICK_US 1000
`define T_HALL_MS 200
`define CARRIER_CYC (`T_CARRIER_US * `CLK_MHZ)
`define TICK_CYC (`T_TICK_US * `CLK_MHZ)
`define HALL_TO_CYC (`T_HALL_MS * 1000 * `CLK_MHZ)
`define ADR_CTRL 8'h00
`define ADR_STAT 8'h04
`define ADR_SPEED 8'h08
`define ADR_GAIN 8'h0C
`define ADR_DUTY 8'h10
`define CTRL_CHOP 0
`define CTRL_CLR 1
`define CTRL_RST 32'h0000_0000
`define GAIN_RST 32'h0000_0210
`define FWD_ZERO 12'h800
`define FWD_TOP 12'hFFF
`define REV_ZERO 12'h7FF
`define CMD_MAX_RPM 2650
`define CMD_K ((`CMD_MAX_RPM * 65536) / (`FWD_TOP - `FWD_ZERO))
`define VBUS_FULL_DV 1110
`define VBUS_TOP 12'hFFF
`define VBUS_K ((`VBUS_FULL_DV * 65536) / `VBUS_TOP)
`define I_TOP 12'hE8B
`define I_SPAN_MA 25000
`define I_OFS_MA 12500
`define I_K ((`I_SPAN_MA * 65536) / `I_TOP)
`define OC_LIMIT_MA 890
`define OV_LIMIT_DV 280
`define UV_LIMIT_DV 140
`define OS_LIMIT_RPM 3000
`define BOOT_V_DV 40
`define V_MAX_DV 240
`define INTEG_LIM (`V_MAX_DV * 256)
`define POLE_PAIRS 4
`define RPM_NUM (60 * 1000000 / `POLE_PAIRS * `CLK_MHZ)
`define HALL_PER_REV 6
`endif

// ### rtl/hsc_pkg.sv
// types shared by the hall commutation controller
package hsc_pkg;
  typedef enum logic [1:0] {
    DRIVE_STOPPED_STATE = 2'b00,
    DRIVE_ACTIVE_STATE = 2'b01,
    DRIVE_ERROR_STATE = 2'b10
  } drive_e;

  typedef struct packed {
    logic [11:0] speedCode;
    logic [11:0] vbusCode;
    logic [11:0] iuCode;
    logic [11:0] iwCode;
  } adc_s;

  typedef struct packed {
    logic uHi;
    logic uLo;
    logic vHi;
    logic vLo;
    logic wHi;
    logic wLo;
  } gate_s;

  typedef struct packed {
    logic hallPat;
    logic hallTo;
    logic overSpd;
    logic underV;
    logic overV;
    logic overI;
  } fault_s;
endpackage

// ### rtl/hall_sensor_commutation_control.sv
// hall sensor commutation controller with wishbone register slave
//
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "hsc_regs.svh"
module hall_sensor_commutation_control #(
  parameter int CarrierCyc = `CARRIER_CYC, // carrier period in cycles
  parameter int TickCyc = `TICK_CYC, // speed loop period in cycles
  parameter int HallToCyc = `HALL_TO_CYC // hall silence limit in cycles
) (
  input wire logic ref_clk, // 100 MHz clock
  input wire logic nrst, // sync reset, active low
  input wire logic wbCyc, // bus cycle
  input wire logic wbStb, // strobe
  input wire logic wbWe, // write enable
  input wire logic [7:0] wbAdr, // byte address
  input wire logic [3:0] wbSel, // byte enables
  input wire logic [31:0] wbDatI, // write data
  output logic [31:0] wbDatO, // read data
  output logic wbAck, // acknowledge
  input wire logic startStopSwitch, // pin, low runs
  input wire logic [2:0] hallIn, // pins, u v w
  input wire logic emergencyStopN, // pin, low stops gates
  input wire logic adcValid, // new conversion set
  input wire hsc_pkg::adc_s adcData, // raw codes
  output var hsc_pkg::gate_s gateOut, // gate levels
  output var hsc_pkg::gate_s gateOe // gate enables
);
  import hsc_pkg::*;

  function automatic logic [15:0] scale(input logic [11:0] code, input logic [31:0] k);
    logic [43:0] p;
    p = {32'h0000_0000, code} * {12'h000, k};
    return p[31:16];
  endfunction

  function automatic logic [15:0] mag(input logic signed [15:0] v);
    return v[15] ? 16'(-v) : v;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // sector 7 marks a pattern no rotor position can give
  function automatic logic [2:0] hallSector(input logic [2:0] h);
    unique case (h)
      3'b101: return 3'd0;
      3'b001: return 3'd1;
      3'b011: return 3'd2;
      3'b010: return 3'd3;
      3'b110: return 3'd4;
      3'b100: return 3'd5;
      default: return 3'd7;
    endcase
  endfunction

  logic swS1_r, swS_r, estS1_r, estS_r;
  logic [2:0] hallS1_r, hallS_r, hallPrev_r;
  logic hallEdge;

  // pins pass two flops; only the second is read
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      swS1_r <= 1'b1;
      swS_r <= 1'b1;
      estS1_r <= 1'b1;
      estS_r <= 1'b1;
      hallS1_r <= 3'h0;
      hallS_r <= 3'h0;
      hallPrev_r <= 3'h0;
    end else begin
      swS1_r <= startStopSwitch;
      swS_r <= swS1_r;
      estS1_r <= emergencyStopN;
      estS_r <= estS1_r;
      hallS1_r <= hallIn;
      hallS_r <= hallS1_r;
      hallPrev_r <= hallS_r;
    end
  end
  assign hallEdge = hallS_r != hallPrev_r;

  logic [31:0] freeRunningTimer_r, carrCnt_r, tickCnt_r, hallToCnt_r;
  logic carrTick, msTick;
  drive_e state_r;
  assign carrTick = carrCnt_r == 32'(CarrierCyc - 1);
  assign msTick = tickCnt_r == 32'(TickCyc - 1);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      freeRunningTimer_r <= 32'h0000_0000;
      carrCnt_r <= 32'h0000_0000;
      tickCnt_r <= 32'h0000_0000;
    end else begin
      freeRunningTimer_r <= freeRunningTimer_r + 32'h0000_0001;
      carrCnt_r <= carrTick ? 32'h0000_0000 : carrCnt_r + 32'h0000_0001;
      tickCnt_r <= msTick ? 32'h0000_0000 : tickCnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst || state_r != DRIVE_ACTIVE_STATE || hallEdge) begin
      hallToCnt_r <= 32'h0000_0000;
    end else if (hallToCnt_r != 32'(HallToCyc)) begin
      hallToCnt_r <= hallToCnt_r + 32'h0000_0001;
    end
  end

  logic [31:0] capHist_r [0:5];
  logic [31:0] period_r;
  logic [2:0] edgeCnt_r;
  logic spdReq_r, boot_r;

  always_ff @(posedge ref_clk) begin
    if (hallEdge) begin
      capHist_r[0] <= freeRunningTimer_r;
      for (int i = 1; i < 6; i++) begin
        capHist_r[i] <= capHist_r[i-1];
      end
      period_r <= freeRunningTimer_r - capHist_r[5];
    end
  end

  // history is trusted only after a full revolution since start
  always_ff @(posedge ref_clk) begin
    if (!nrst || state_r != DRIVE_ACTIVE_STATE) begin
      edgeCnt_r <= 3'h0;
      boot_r <= 1'b1;
    end else begin
      if (hallEdge && edgeCnt_r != 3'(`HALL_PER_REV)) begin
        edgeCnt_r <= edgeCnt_r + 3'h1;
      end
      if (edgeCnt_r == 3'(`HALL_PER_REV)) begin
        boot_r <= 1'b0;
      end
    end
  end

  logic [15:0] cmdRpm_r, vbusDv_r, measRpm_r, vCmd_r, dutyCmp_r;
  logic signed [15:0] iuMa_r, iwMa_r;
  logic revRot_r;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cmdRpm_r <= 16'h0000;
      revRot_r <= 1'b0;
      vbusDv_r <= 16'h0000;
      iuMa_r <= 16'sh0000;
      iwMa_r <= 16'sh0000;
    end else if (adcValid) begin
      revRot_r <= !adcData.speedCode[11];
      cmdRpm_r <= adcData.speedCode[11]
        ? scale(adcData.speedCode - `FWD_ZERO, `CMD_K)
        : scale(`REV_ZERO - adcData.speedCode, `CMD_K);
      vbusDv_r <= scale(adcData.vbusCode, `VBUS_K);
      iuMa_r <= $signed(scale(adcData.iuCode, `I_K) - 16'(`I_OFS_MA));
      iwMa_r <= $signed(scale(adcData.iwCode, `I_K) - 16'(`I_OFS_MA));
    end
  end

  logic divBusy_r, divSel_r, divDone_r, dutyReq_r, remGe, takeSpd, takeDuty;
  logic [31:0] divNum_r, divDen_r, divRem_r;
  logic [4:0] divCnt_r;
  logic [32:0] remSh;
  assign remSh = {divRem_r, divNum_r[31]};
  assign remGe = remSh >= {1'b0, divDen_r};
  assign takeSpd = !divBusy_r && spdReq_r;
  assign takeDuty = !divBusy_r && !spdReq_r && dutyReq_r;

  // a new request in the cycle its old one is taken stays pending
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      spdReq_r <= 1'b0;
      dutyReq_r <= 1'b0;
    end else begin
      spdReq_r <= (hallEdge && edgeCnt_r == 3'(`HALL_PER_REV)) || (spdReq_r && !takeSpd);
      dutyReq_r <= msTick || (dutyReq_r && !takeDuty);
    end
  end

  // one shared serial divider; 32 cycles per quotient saves two arrays
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      divBusy_r <= 1'b0;
      divSel_r <= 1'b0;
      divDone_r <= 1'b0;
      divNum_r <= 32'h0000_0000;
      divDen_r <= 32'h0000_0000;
      divRem_r <= 32'h0000_0000;
      divCnt_r <= 5'h00;
    end else if (takeSpd || takeDuty) begin
      divBusy_r <= 1'b1;
      divSel_r <= takeDuty;
      divDone_r <= 1'b0;
      divNum_r <= takeSpd ? 32'(`RPM_NUM) : 32'({16'h0000, vCmd_r} * 32'(CarrierCyc));
      divDen_r <= takeSpd ? period_r : {16'h0000, vbusDv_r};
      divRem_r <= 32'h0000_0000;
      divCnt_r <= 5'h00;
    end else begin
      divDone_r <= divBusy_r && divCnt_r == 5'h1F;
      if (divBusy_r) begin
        divRem_r <= remGe ? 32'(remSh - {1'b0, divDen_r}) : remSh[31:0];
        divNum_r <= {divNum_r[30:0], remGe};
        divCnt_r <= divCnt_r + 5'h01;
        divBusy_r <= divCnt_r != 5'h1F;
      end
    end
  end

  // a stale speed from the last run would trip overspeed at every restart
  always_ff @(posedge ref_clk) begin
    if (!nrst || state_r != DRIVE_ACTIVE_STATE) begin
      measRpm_r <= 16'h0000;
    end else if (divDone_r && !divSel_r) begin
      measRpm_r <= divNum_r[31:16] != 16'h0000 ? 16'hFFFF : divNum_r[15:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      dutyCmp_r <= 16'h0000;
    end else if (divDone_r && divSel_r) begin
      dutyCmp_r <= divNum_r > 32'(CarrierCyc) ? 16'(CarrierCyc) : divNum_r[15:0];
    end
  end

  logic [31:0] ctrl_r, gain_r;
  logic signed [31:0] spdErr, integ_r, integSum, integNxt, vRaw;

  always_comb begin
    spdErr = 32'($signed({1'b0, cmdRpm_r})) - 32'($signed({1'b0, measRpm_r}));
    integSum = integ_r + spdErr * $signed({24'h00_0000, gain_r[15:8]});
    integNxt = integSum > `INTEG_LIM ? `INTEG_LIM
             : (integSum < -`INTEG_LIM ? -`INTEG_LIM : integSum);
    vRaw = (spdErr * $signed({24'h00_0000, gain_r[7:0]}) + integNxt) >>> 8;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst || state_r != DRIVE_ACTIVE_STATE) begin
      integ_r <= 32'sh0000_0000;
      vCmd_r <= 16'h0000;
    end else if (boot_r) begin
      vCmd_r <= 16'(`BOOT_V_DV);
    end else if (msTick) begin
      integ_r <= integNxt;
      vCmd_r <= vRaw < 0 ? 16'h0000 : (vRaw > `V_MAX_DV ? 16'(`V_MAX_DV) : vRaw[15:0]);
    end
  end

  fault_s newFault, fault_r;
  logic errEvent, clrReq, wbHit, wbWr, ack_r;
  assign wbHit = wbCyc && wbStb && !ack_r;
  assign wbWr = wbHit && wbWe;
  assign clrReq = wbWr && wbAdr == `ADR_CTRL && wbSel[0] && wbDatI[`CTRL_CLR];

  always_comb begin
    newFault = '0;
    if (state_r == DRIVE_ACTIVE_STATE) begin
      if (carrTick) begin
        newFault.overI = mag(iuMa_r) > `OC_LIMIT_MA || mag(iwMa_r) > `OC_LIMIT_MA
                      || mag(16'(-(iuMa_r + iwMa_r))) > `OC_LIMIT_MA;
        newFault.overV = vbusDv_r > `OV_LIMIT_DV;
        newFault.underV = vbusDv_r < `UV_LIMIT_DV;
        newFault.overSpd = measRpm_r > `OS_LIMIT_RPM;
      end
      newFault.hallTo = hallToCnt_r == 32'(HallToCyc);
      newFault.hallPat = hallEdge && hallSector(hallS_r) == 3'd7;
    end
    if (!estS_r) begin
      newFault.overI = 1'b1;
    end
  end
  assign errEvent = |newFault;

  // new fault wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      fault_r <= '0;
    end else begin
      fault_r <= (clrReq ? '0 : fault_r) | newFault;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_r <= DRIVE_STOPPED_STATE;
    end else if (errEvent) begin
      state_r <= DRIVE_ERROR_STATE;
    end else begin
      unique case (state_r)
        DRIVE_STOPPED_STATE: if (!swS_r) state_r <= DRIVE_ACTIVE_STATE;
        DRIVE_ACTIVE_STATE: if (swS_r) state_r <= DRIVE_STOPPED_STATE;
        DRIVE_ERROR_STATE: if (clrReq) state_r <= DRIVE_STOPPED_STATE;
        default: state_r <= DRIVE_STOPPED_STATE;
      endcase
    end
  end

  logic [31:0] rdData, datO_r;
  always_comb begin
    unique case (wbAdr)
      `ADR_CTRL: rdData = ctrl_r;
      `ADR_STAT: rdData = {22'h00_0000, revRot_r, fault_r, boot_r, state_r};
      `ADR_SPEED: rdData = {16'h0000, measRpm_r};
      `ADR_GAIN: rdData = gain_r;
      `ADR_DUTY: rdData = {16'h0000, dutyCmp_r};
      default: rdData = 32'h0000_0000;
    endcase
  end

  // clear bit is a pulse and never stored
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ack_r <= 1'b0;
      datO_r <= 32'h0000_0000;
      ctrl_r <= `CTRL_RST;
      gain_r <= `GAIN_RST;
    end else begin
      ack_r <= wbHit;
      if (wbHit) begin
        datO_r <= rdData;
      end
      if (wbWr && wbAdr == `ADR_CTRL) begin
        ctrl_r <= merge(ctrl_r, wbDatI, wbSel) & 32'h0000_0001;
      end
      if (wbWr && wbAdr == `ADR_GAIN) begin
        gain_r <= merge(gain_r, wbDatI, wbSel) & 32'h0000_FFFF;
      end
    end
  end
  assign wbAck = ack_r;
  assign wbDatO = datO_r;

  logic [2:0] sec, raw, upM, loM, hiOn, loOn;
  logic chopUp, pwmOn;
  gate_s gateOut_r, gateOe_r;

  always_comb begin
    raw = hallSector(hallS_r);
    sec = (!revRot_r || raw == 3'd7) ? raw : (raw >= 3'd3 ? raw - 3'd3 : raw + 3'd3);
    unique case (sec)
      3'd0: begin upM = 3'b100; loM = 3'b010; end
      3'd1: begin upM = 3'b100; loM = 3'b001; end
      3'd2: begin upM = 3'b010; loM = 3'b001; end
      3'd3: begin upM = 3'b010; loM = 3'b100; end
      3'd4: begin upM = 3'b001; loM = 3'b100; end
      3'd5: begin upM = 3'b001; loM = 3'b010; end
      default: begin upM = 3'b000; loM = 3'b000; end
    endcase
    // even sectors start a high leg, odd ones a low leg
    chopUp = !sec[0];
    pwmOn = carrCnt_r < {16'h0000, dutyCmp_r};
    hiOn = upM & {3{pwmOn || !chopUp}};
    loOn = loM & {3{pwmOn || chopUp}};
    if (ctrl_r[`CTRL_CHOP]) begin
      hiOn = hiOn | (chopUp ? 3'b000 : loM & {3{!pwmOn}});
      loOn = loOn | (chopUp ? upM & {3{!pwmOn}} : 3'b000);
    end
    if (state_r != DRIVE_ACTIVE_STATE || errEvent) begin
      hiOn = 3'b000;
      loOn = 3'b000;
    end
  end

  // no dead time here; the gate driver is expected to insert it
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      gateOut_r <= '0;
      gateOe_r <= '1;
    end else begin
      gateOut_r <= {hiOn[2], loOn[2], hiOn[1], loOn[1], hiOn[0], loOn[0]};
      gateOe_r <= estS_r ? '1 : '0;
    end
  end
  assign gateOut = gateOut_r;
  assign gateOe = gateOe_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  estop_hiz_a: assert property (!estS_r |=> gateOe_r == '0)
    else $error("gates not released on emergency stop");
  error_entry_a: assert property (errEvent |=> state_r == DRIVE_ERROR_STATE)
    else $error("error event did not reach error state");
  error_quiet_a: assert property (state_r == DRIVE_ERROR_STATE |=> gateOut_r == '0)
    else $error("gates driven in error state");
  run_start_a: assert property (state_r == DRIVE_STOPPED_STATE && !swS_r && !errEvent
    |=> state_r == DRIVE_ACTIVE_STATE)
    else $error("run request ignored");
  capture_time_a: assert property (hallEdge |=> capHist_r[0] == $past(freeRunningTimer_r))
    else $error("hall edge capture wrong");
  boot_volt_a: assert property (state_r == DRIVE_ACTIVE_STATE && boot_r ##1
    state_r == DRIVE_ACTIVE_STATE |-> vCmd_r == 16'(`BOOT_V_DV))
    else $error("boot voltage not applied");
  overvolt_trip_a: assert property (state_r == DRIVE_ACTIVE_STATE && carrTick
    && vbusDv_r > `OV_LIMIT_DV |=> fault_r.overV && state_r == DRIVE_ERROR_STATE)
    else $error("overvoltage not tripped");
  bus_ack_a: assert property (wbHit |=> ack_r ##1 !ack_r)
    else $error("bus ack not single cycle");
  hall_bad_a: assert property (state_r == DRIVE_ACTIVE_STATE && hallEdge
    && (hallS_r == 3'b000 || hallS_r == 3'b111) |=> fault_r.hallPat)
    else $error("bad hall pattern not flagged");
endmodule // hall_sensor_commutation_control
`default_nettype wire

// ### tb/motor_partner.sv
// behavioural inverter, hall sensor and motor model
`timescale 1ns/10ps
`default_nettype none
module motor_partner (
  input wire logic ref_clk, // clock
  input wire logic run, // rotor may turn
  input wire logic [15:0] per, // cycles between hall edges, minus one
  input wire logic [2:0] fixPat, // hall pattern while held
  input wire hsc_pkg::adc_s codes, // analog levels to report
  input wire hsc_pkg::gate_s gateOut, // gate levels
  input wire hsc_pkg::gate_s gateOe, // gate enables
  output logic [2:0] hallIn, // hall pins
  output logic adcValid, // conversion pulse
  output var hsc_pkg::adc_s adcData // conversion codes
);
  import hsc_pkg::*;
  logic [2:0] sec = 3'h0;
  logic [15:0] cnt = 16'h0000;
  logic [5:0] tick = 6'h00;
  logic vld = 1'b0;
  logic [2:0] pat [6] = '{3'h5, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4};
  // turns only while energised, so a released bridge ends the hall edges
  always @(posedge ref_clk) begin
    if (run && (|gateOut) && (&gateOe) && cnt >= per) begin
      cnt <= 16'h0000;
      sec <= (sec == 3'h5) ? 3'h0 : sec + 3'h1;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
  always @(posedge ref_clk) begin
    tick <= (tick == 6'h31) ? 6'h00 : tick + 6'h01;
    vld <= (tick == 6'h31);
  end
  assign hallIn = run ? pat[sec] : fixPat;
  assign adcValid = vld;
  assign adcData = codes;
endmodule // motor_partner
`default_nettype wire

// ### tb/hall_sensor_commutation_control_tb_top.sv
// self-checking bench for the hall commutation controller
`timescale 1ns/10ps
`default_nettype none
module hall_sensor_commutation_control_tb_top;
  import hsc_pkg::*;
  localparam int Car = 50;
  localparam logic [31:0] NoChk = 32'h0000_0000;
  localparam logic [31:0] AllChk = 32'hFFFF_FFFF;
  localparam adc_s Normal = '{12'hC00, 12'h376, 12'h745, 12'h745};
  typedef struct packed {logic [31:0] exp; logic [31:0] msk;} note_s;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h0000_0000;
  logic [31:0] wbDatO;
  logic wbAck;
  logic startStopSwitch = 1'b1;
  logic emergencyStopN = 1'b1;
  logic run = 1'b0;
  logic [15:0] per = 16'h03E8;
  logic [2:0] fixPat = 3'h1;
  adc_s codes = Normal;
  logic [2:0] hallIn;
  logic adcValid;
  adc_s adcData;
  gate_s gateOut;
  gate_s gateOe;
  note_s expQ[$];
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int seed = 10;
  int hiCnt, loCnt, cuCnt;
  int fb[7] = '{4, 5, 3, 8, 6, 3, 7};
  logic [31:0] r1, r2;

  always #5 ref_clk = ~ref_clk;

  hall_sensor_commutation_control #(.CarrierCyc(Car), .TickCyc(500), .HallToCyc(2000))
    i_hall_sensor_commutation_control (.ref_clk(ref_clk), .nrst(nrst), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI),
    .wbDatO(wbDatO), .wbAck(wbAck), .startStopSwitch(startStopSwitch), .hallIn(hallIn),
    .emergencyStopN(emergencyStopN), .adcValid(adcValid), .adcData(adcData),
    .gateOut(gateOut), .gateOe(gateOe));
  motor_partner i_motor_partner (.ref_clk(ref_clk), .run(run), .per(per), .fixPat(fixPat),
    .codes(codes), .gateOut(gateOut), .gateOe(gateOe), .hallIn(hallIn),
    .adcValid(adcValid), .adcData(adcData));

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] exp, input logic [31:0] got,
                            input logic [31:0] msk);
    samples_checked++;
    if ((got & msk) !== (exp & msk)) begin
      err_count++;
      $display("Error register read expected %h seen %h", exp & msk, got & msk);
    end
  endtask

  task automatic check_gate(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // read data is judged by the watcher, in request order
  always @(posedge ref_clk) begin
    note_s n;
    if (nrst === 1'b1 && wbAck === 1'b1 && expQ.size() > 0) begin
      n = expQ.pop_front();
      if (n.msk != NoChk) check_word(n.exp, wbDatO, n.msk);
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      $display("Error run length expected under 30000 cycles seen %0d", cycles);
      report_and_stop();
    end
  end

  task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d,
                    input logic [3:0] s, input logic [31:0] msk);
    @(posedge ref_clk);
    expQ.push_back('{d, we ? NoChk : msk});
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbSel <= s;
    wbDatI <= d;
    do @(posedge ref_clk); while (wbAck !== 1'b1);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic fault_case(input int k);
    startStopSwitch <= 1'b0;
    repeat (10) @(posedge ref_clk);
    case (k)
      0: codes.vbusCode <= 12'h600;
      1: codes.vbusCode <= 12'h100;
      2: codes.iuCode <= 12'h7D0;
      3: fixPat <= 3'h7;
      4: run <= 1'b1;
      5: emergencyStopN <= 1'b0;
      default: ;
    endcase
    repeat (k == 4 ? 9000 : k == 5 ? 4 : k == 6 ? 2100 : 120) @(posedge ref_clk);
    if (k == 5) check_gate("gate enables", 16'h0000, {10'h000, gateOe});
    else check_gate("gate levels", 16'h0000, {10'h000, gateOut});
    wb(8'h04, 1'b0, 32'h0000_0002 | (32'h1 << fb[k]), 4'hF, 32'h0000_01FB);
    run <= 1'b0;
    fixPat <= 3'h1;
    emergencyStopN <= 1'b1;
    codes <= Normal;
    startStopSwitch <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wb(8'h00, 1'b1, 32'h0000_0002, 4'hF, NoChk);
    wb(8'h04, 1'b0, NoChk, 4'hF, 32'h0000_01FB);
  endtask

  initial begin
    r1 = $random(seed);
    r2 = $random(seed);
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    check_gate("gate enables", 16'h003F, {10'h000, gateOe});
    wb(8'h00, 1'b0, NoChk, 4'hF, AllChk);
    wb(8'h0C, 1'b0, 32'h0000_0210, 4'hF, 32'h0000_FFFF);
    wb(8'h04, 1'b0, 32'h0000_0004, 4'hF, 32'h0000_03FF);
    wb(8'h20, 1'b1, r1, 4'hF, NoChk);
    wb(8'h20, 1'b0, NoChk, 4'hF, AllChk);
    wb(8'h0C, 1'b1, r1, 4'hF, NoChk);
    wb(8'h0C, 1'b1, r2, 4'h1, NoChk);
    wb(8'h0C, 1'b0, {16'h0000, r1[15:8], r2[7:0]}, 4'hF, 32'h0000_FFFF);
    wb(8'h0C, 1'b1, 32'h0000_0210, 4'hF, NoChk);
    codes.speedCode <= 12'h400;
    repeat (60) @(posedge ref_clk);
    wb(8'h04, 1'b0, 32'h0000_0200, 4'hF, 32'h0000_0200);
    codes.speedCode <= 12'hC00;
    repeat (60) @(posedge ref_clk);
    wb(8'h04, 1'b0, NoChk, 4'hF, 32'h0000_0200);
    startStopSwitch <= 1'b0;
    repeat (5) @(posedge ref_clk);
    wb(8'h04, 1'b0, 32'h0000_0005, 4'hF, 32'h0000_0007);
    repeat (600) @(posedge ref_clk);
    // 4.0 V over 24.0 V of a 50 cycle carrier
    wb(8'h10, 1'b0, 32'h0000_0008, 4'hF, 32'h0000_FFFF);
    for (int m = 1; m >= 0; m--) begin
      wb(8'h00, 1'b1, m, 4'hF, NoChk);
      hiCnt = 0;
      loCnt = 0;
      cuCnt = 0;
      repeat (Car) begin
        @(posedge ref_clk);
        hiCnt += (gateOut.wHi === 1'b1);
        loCnt += (gateOut.wLo === 1'b1);
        cuCnt += (gateOut.uHi === 1'b1);
      end
      check_gate("steady leg", 16'(Car), 16'(cuCnt));
      check_gate("chopped leg", 16'h0008, 16'(loCnt));
      check_gate("complement leg", 16'(m ? Car - 8 : 0), 16'(hiCnt));
      check_gate("idle legs", 16'h0000, {13'h0000, gateOut.uLo, gateOut.vHi, gateOut.vLo});
    end
    startStopSwitch <= 1'b1;
    repeat (5) @(posedge ref_clk);
    wb(8'h04, 1'b0, 32'h0000_0004, 4'hF, 32'h0000_0007);
    for (int k = 0; k < 7; k++) fault_case(k);
    report_and_stop();
  end
endmodule // hall_sensor_commutation_control_tb_top
`default_nettype wire
